// [hw/adcsp_pkg.sv]
package adcsp_pkg;

    // ==========================================================
    // Word and pin constants
    localparam int unsigned WORD_W        = 24;
    localparam int unsigned PIN_W         = 7;
    // Pin sync vector: mode, rd strobe, wr strobe, select, sclk, din, sync
    localparam logic [6:0]  PIN_RST       = 7'h35;
    localparam int unsigned PIN_MODE      = 6;
    localparam int unsigned PIN_RFS       = 5;
    localparam int unsigned PIN_TFS       = 4;
    localparam int unsigned PIN_SEL       = 3;
    localparam int unsigned PIN_SCLK      = 2;
    localparam int unsigned PIN_DIN       = 1;
    localparam int unsigned PIN_SYNC      = 0;

    // ==========================================================
    // Timing
    localparam int unsigned CLK_NS        = 20;
    localparam int unsigned EXT_DIV_MIN   = 5;
    localparam int unsigned SEL_SETUP_MCK = 2;
    localparam int unsigned SEL_SETUP_CYC = SEL_SETUP_MCK;
    localparam int unsigned SYNC_MIN_NS   = 1000;
    localparam int unsigned SYNC_MIN_CYC  =
        (SYNC_MIN_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned SELF_HIGH_CYC = 4;
    localparam int unsigned SELF_LOW_CYC  = 3 * SELF_HIGH_CYC;
    localparam int unsigned HOST_HALF_CYC = 8;
    localparam int unsigned TAIL_CYC      = 6;
    localparam int unsigned CNT_W         = 8;

    // ==========================================================
    // States
    typedef enum logic [1:0] {
        DEV_IDLE,
        DEV_SHIFT,
        DEV_DONE
    } adcsp_dev_state_type;

    typedef enum logic [2:0] {
        HOST_IDLE,
        HOST_SETUP,
        HOST_SHIFT,
        HOST_TAIL,
        HOST_GAP,
        HOST_SYNC
    } adcsp_host_state_type;

endpackage

// [hw/adcsp_if.sv]
`timescale 1ns/10ps
interface adcsp_if;
    logic mode_self;
    logic sclk_dev;
    logic sclk_dev_oe;
    logic sclk_host;
    logic sclk_host_oe;
    logic sclk;
    logic read_frame_strobe_n;
    logic write_frame_strobe_n;
    logic register_select;
    logic dout;
    logic dout_oe;
    logic dout_line;
    logic din;
    logic result_ready_n;
    logic filter_sync_n;

    // ==========================================================
    // Wire resolution, pulled high when nobody drives
    assign sclk = sclk_dev_oe ? sclk_dev :
                  (sclk_host_oe ? sclk_host : 1'b1);
    assign dout_line = dout_oe ? dout : 1'b1;

    modport dev (
        input  mode_self,
        output sclk_dev,
        output sclk_dev_oe,
        input  sclk,
        input  read_frame_strobe_n,
        input  write_frame_strobe_n,
        input  register_select,
        output dout,
        output dout_oe,
        input  din,
        output result_ready_n,
        input  filter_sync_n
    );

    modport host (
        output mode_self,
        output sclk_host,
        output sclk_host_oe,
        input  sclk,
        output read_frame_strobe_n,
        output write_frame_strobe_n,
        output register_select,
        input  dout_line,
        output din,
        input  result_ready_n,
        output filter_sync_n
    );
endinterface

// [hw/adcsp_device.sv]
`timescale 1ns/10ps
module adcsp_device
    import adcsp_pkg::*;
#(
    parameter int unsigned WORD_W = adcsp_pkg::WORD_W
) (
    input  wire logic              clk,
    input  wire logic              rst,
    adcsp_if.dev                   bus,
    input  wire logic [WORD_W-1:0] ctrl_word,
    input  wire logic [WORD_W-1:0] result_word,
    input  wire logic              result_valid,
    output logic      [WORD_W-1:0] wr_word,
    output logic                   wr_to_data,
    output logic                   wr_valid,
    output logic                   filter_reset
);
    import adcsp_pkg::*;

    localparam int unsigned SELF_PERIOD = SELF_HIGH_CYC + SELF_LOW_CYC;

    // ==========================================================
    // Pin synchronisers
    logic [PIN_W-1:0]    pin_meta;
    logic [PIN_W-1:0]    pin_sync;
    logic                sclk_prev;
    adcsp_dev_state_type state;
    logic                is_read;
    logic                target_data;
    logic [WORD_W-1:0]   shreg;
    logic [CNT_W-1:0]    bit_cnt;
    logic [CNT_W-1:0]    gen_cnt;
    logic                mode_self;
    logic                rd_low;
    logic                wr_low;
    logic                strobe_high;
    logic                gen_fall;
    logic                gen_rise;
    logic                rise;
    logic                fall;
    logic                word_end;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pin_meta <= PIN_RST;
            pin_sync <= PIN_RST;
        end else begin
            pin_meta <= {bus.mode_self, bus.read_frame_strobe_n,
                         bus.write_frame_strobe_n, bus.register_select,
                         bus.sclk, bus.din, bus.filter_sync_n};
            pin_sync <= pin_meta;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sclk_prev <= 1'b1;
        end else begin
            sclk_prev <= pin_sync[PIN_SCLK];
        end
    end

    assign mode_self = pin_sync[PIN_MODE];
    assign rd_low    = ~pin_sync[PIN_RFS];
    assign wr_low    = ~pin_sync[PIN_TFS];
    assign strobe_high = is_read ? ~rd_low : ~wr_low;

    // ==========================================================
    // Serial clock edges, own or external
    assign gen_fall = (gen_cnt == CNT_W'(SELF_HIGH_CYC - 1));
    assign gen_rise = (gen_cnt == CNT_W'(SELF_PERIOD - 1));

    always_comb begin
        if (mode_self) begin
            rise = (state == DEV_SHIFT) && gen_rise;
            fall = (state == DEV_SHIFT) && gen_fall;
        end else begin
            // Edges seen whenever they come; pauses hold state
            rise = (state == DEV_SHIFT) && pin_sync[PIN_SCLK]
                   && ~sclk_prev;
            fall = (state == DEV_SHIFT) && ~pin_sync[PIN_SCLK]
                   && sclk_prev;
        end
    end

    assign word_end = fall && (bit_cnt == CNT_W'(WORD_W));

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            gen_cnt <= '0;
        end else if (state != DEV_SHIFT || !mode_self) begin
            gen_cnt <= '0;
        end else if (gen_rise) begin
            gen_cnt <= '0;
        end else begin
            gen_cnt <= gen_cnt + 1'b1;
        end
    end

    assign bus.sclk_dev    = (gen_cnt < CNT_W'(SELF_HIGH_CYC));
    assign bus.sclk_dev_oe = mode_self && (state == DEV_SHIFT);

    // ==========================================================
    // Frame sequencing
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state       <= DEV_IDLE;
            is_read     <= 1'b0;
            target_data <= 1'b0;
        end else begin
            unique case (state)
                DEV_IDLE: begin
                    if (rd_low || wr_low) begin
                        state       <= DEV_SHIFT;
                        is_read     <= rd_low;
                        target_data <= pin_sync[PIN_SEL];
                    end
                end
                DEV_SHIFT: begin
                    if (strobe_high) begin
                        state <= DEV_IDLE;
                    end else if (word_end) begin
                        state <= DEV_DONE;
                    end
                end
                DEV_DONE: begin
                    if (strobe_high) begin
                        state <= DEV_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            bit_cnt <= '0;
        end else if (state == DEV_IDLE) begin
            bit_cnt <= '0;
        end else if (rise) begin
            bit_cnt <= bit_cnt + 1'b1;
        end
    end

    // ==========================================================
    // Shift register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            shreg <= '0;
        end else if (state == DEV_IDLE) begin
            if (pin_sync[PIN_SEL]) begin
                shreg <= result_word;
            end else begin
                shreg <= ctrl_word;
            end
        end else if (is_read) begin
            if (fall && bit_cnt != '0 && !word_end) begin
                shreg <= {shreg[WORD_W-2:0], 1'b0};
            end
        end else if (rise) begin
            shreg <= {shreg[WORD_W-2:0], pin_sync[PIN_DIN]};
        end
    end

    assign bus.dout    = shreg[WORD_W-1];
    assign bus.dout_oe = is_read && (state != DEV_IDLE);

    // ==========================================================
    // Write delivery and result flag
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_word    <= '0;
            wr_to_data <= 1'b0;
            wr_valid   <= 1'b0;
        end else begin
            wr_valid <= word_end && !is_read;
            if (word_end && !is_read) begin
                wr_word    <= shreg;
                wr_to_data <= target_data;
            end
        end
    end

    logic ready_flag;

    // New result wins over a read that ends in the same cycle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ready_flag <= 1'b0;
        end else if (result_valid) begin
            ready_flag <= 1'b1;
        end else if (word_end && is_read && target_data) begin
            ready_flag <= 1'b0;
        end
    end

    assign bus.result_ready_n = ~ready_flag;

    // ==========================================================
    // Filter synchronisation
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            filter_reset <= 1'b0;
        end else begin
            filter_reset <= ~pin_sync[PIN_SYNC];
        end
    end

endmodule

// [hw/adcsp_host.sv]
`timescale 1ns/10ps
module adcsp_host
    import adcsp_pkg::*;
#(
    parameter int unsigned WORD_W    = adcsp_pkg::WORD_W,
    parameter int unsigned HALF_CYC  = adcsp_pkg::HOST_HALF_CYC
) (
    input  wire logic              clk,
    input  wire logic              rst,
    adcsp_if.host                  bus,
    input  wire logic              self_clock_mode,
    input  wire logic              start,
    input  wire logic              start_read,
    input  wire logic              start_select,
    input  wire logic [WORD_W-1:0] start_word,
    input  wire logic              filter_sync_req,
    output logic                   busy,
    output logic      [WORD_W-1:0] rd_word,
    output logic                   rd_valid,
    output logic                   result_ready
);
    import adcsp_pkg::*;

    // ==========================================================
    // Pin synchronisers: sclk, data line, ready
    logic [2:0]           in_meta;
    logic [2:0]           in_sync;
    logic                 sclk_prev;
    adcsp_host_state_type state;
    logic                 mode_q;
    logic                 reading;
    logic                 select_q;
    logic [WORD_W-1:0]    shreg;
    logic [CNT_W-1:0]     bit_cnt;
    logic [CNT_W-1:0]     wait_cnt;
    logic                 sclk_gen;
    logic                 rise;
    logic                 fall;
    logic                 half_done;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            in_meta <= 3'h7;
            in_sync <= 3'h7;
        end else begin
            in_meta <= {bus.sclk, bus.dout_line, bus.result_ready_n};
            in_sync <= in_meta;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sclk_prev <= 1'b1;
        end else begin
            sclk_prev <= in_sync[2];
        end
    end

    assign result_ready = ~in_sync[0];

    // ==========================================================
    // Serial clock: own divider or device clock
    // One long high half mid-word gives the device a paused clock
    assign half_done = (sclk_gen && bit_cnt == CNT_W'(WORD_W / 2)) ?
                       (wait_cnt == CNT_W'(4 * HALF_CYC - 1)) :
                       (wait_cnt == CNT_W'(HALF_CYC - 1));

    always_comb begin
        if (mode_q) begin
            rise = (state == HOST_SHIFT) && in_sync[2] && ~sclk_prev;
            fall = (state == HOST_SHIFT) && ~in_sync[2] && sclk_prev;
        end else begin
            // Half period of HALF_CYC keeps the rate under clk/5
            rise = (state == HOST_SHIFT) && half_done && !sclk_gen;
            fall = (state == HOST_SHIFT) && half_done && sclk_gen;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sclk_gen <= 1'b1;
        end else if (!(state inside {HOST_SHIFT, HOST_TAIL}) || mode_q) begin
            // Held low through the tail so the last low half keeps its width
            sclk_gen <= 1'b1;
        end else if (rise || fall) begin
            sclk_gen <= ~sclk_gen;
        end
    end

    assign bus.sclk_host    = sclk_gen;
    assign bus.sclk_host_oe = !mode_q;

    // ==========================================================
    // Frame sequencing
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state    <= HOST_IDLE;
            mode_q   <= 1'b0;
            reading  <= 1'b0;
            select_q <= 1'b0;
            wait_cnt <= '0;
        end else begin
            unique case (state)
                HOST_IDLE: begin
                    mode_q   <= self_clock_mode;
                    wait_cnt <= '0;
                    if (filter_sync_req) begin
                        state <= HOST_SYNC;
                    end else if (start) begin
                        state    <= HOST_SETUP;
                        reading  <= start_read;
                        select_q <= start_select;
                    end
                end
                HOST_SETUP: begin
                    wait_cnt <= wait_cnt + 1'b1;
                    if (wait_cnt == CNT_W'(SEL_SETUP_CYC)) begin
                        state    <= HOST_SHIFT;
                        wait_cnt <= '0;
                    end
                end
                HOST_SHIFT: begin
                    wait_cnt <= (half_done || mode_q) ? '0 :
                                wait_cnt + 1'b1;
                    // Device clock ends on the last rise: the device
                    // releases the line before its final fall shows
                    if (mode_q ? (rise && bit_cnt == CNT_W'(WORD_W - 1))
                               : (fall && bit_cnt == CNT_W'(WORD_W))) begin
                        state    <= HOST_TAIL;
                        wait_cnt <= '0;
                    end
                end
                HOST_TAIL: begin
                    wait_cnt <= wait_cnt + 1'b1;
                    if (wait_cnt == CNT_W'(TAIL_CYC - 1)) begin
                        state    <= HOST_GAP;
                        wait_cnt <= '0;
                    end
                end
                HOST_GAP: begin
                    wait_cnt <= wait_cnt + 1'b1;
                    if (wait_cnt == CNT_W'(TAIL_CYC - 1)) begin
                        state <= HOST_IDLE;
                    end
                end
                HOST_SYNC: begin
                    wait_cnt <= wait_cnt + 1'b1;
                    if (wait_cnt == CNT_W'(SYNC_MIN_CYC - 1)) begin
                        state <= HOST_IDLE;
                    end
                end
            endcase
        end
    end

    assign busy = (state != HOST_IDLE);
    assign bus.mode_self = mode_q;
    assign bus.register_select = select_q;
    assign bus.read_frame_strobe_n =
        !(reading && (state == HOST_SHIFT || state == HOST_TAIL));
    assign bus.write_frame_strobe_n =
        !(!reading && (state == HOST_SHIFT || state == HOST_TAIL));
    assign bus.filter_sync_n = (state != HOST_SYNC);

    // ==========================================================
    // Bit counting and data
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            bit_cnt <= '0;
        end else if (state != HOST_SHIFT) begin
            bit_cnt <= '0;
        end else if (rise) begin
            bit_cnt <= bit_cnt + 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            shreg <= '0;
        end else if (state == HOST_IDLE) begin
            shreg <= start_word;
        end else if (state == HOST_SHIFT) begin
            if (reading && rise) begin
                shreg <= {shreg[WORD_W-2:0], in_sync[1]};
            end else if (!reading && fall && bit_cnt != '0
                         && bit_cnt != CNT_W'(WORD_W)) begin
                shreg <= {shreg[WORD_W-2:0], 1'b0};
            end
        end
    end

    assign bus.din = shreg[WORD_W-1];

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rd_word  <= '0;
            rd_valid <= 1'b0;
        end else begin
            rd_valid <= 1'b0;
            if (state == HOST_TAIL && wait_cnt == '0 && reading) begin
                rd_word  <= shreg;
                rd_valid <= 1'b1;
            end
        end
    end

endmodule

// [dv/adcsp_props.sv]
`timescale 1ns/10ps
module adcsp_props (
    input wire logic clk,
    input wire logic rst,
    input wire logic mode_self,
    input wire logic sclk_dev,
    input wire logic sclk_dev_oe,
    input wire logic sclk_host,
    input wire logic sclk_host_oe,
    input wire logic sclk,
    input wire logic read_frame_strobe_n,
    input wire logic write_frame_strobe_n,
    input wire logic register_select,
    input wire logic dout,
    input wire logic dout_oe,
    input wire logic din
);
    // ==========================================================
    // Clocking and helpers
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    logic       sclk_q;
    logic [3:0] since_fall;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sclk_q <= 1'b1;
        end else begin
            sclk_q <= sclk;
        end
    end

    // Cycles since the last falling edge of the serial clock line
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            since_fall <= 4'hF;
        end else if (sclk_q && !sclk) begin
            since_fall <= 4'h0;
        end else if (since_fall != 4'hF) begin
            since_fall <= since_fall + 4'h1;
        end
    end

    // ==========================================================
    // Properties
    property p_ext_no_drive;
        (!mode_self)[*4] |-> !sclk_dev_oe;
    endproperty
    a_ext_no_drive: assert property (p_ext_no_drive)
        else $error("device drives clock in external mode");

    property p_idle_release;
        (read_frame_strobe_n && write_frame_strobe_n)[*5]
            |-> !sclk_dev_oe && !dout_oe;
    endproperty
    a_idle_release: assert property (p_idle_release)
        else $error("device pins not released outside a frame");

    property p_self_start;
        mode_self && ($fell(read_frame_strobe_n)
            || $fell(write_frame_strobe_n)) |-> ##[1:8] sclk_dev_oe;
    endproperty
    a_self_start: assert property (p_self_start)
        else $error("self clock did not start");

    property p_first_bit;
        $fell(read_frame_strobe_n) |-> ##[1:6] dout_oe;
    endproperty
    a_first_bit: assert property (p_first_bit)
        else $error("first read bit not presented");

    property p_dout_on_fall;
        $changed(dout) && dout_oe && $past(dout_oe) && !read_frame_strobe_n
            |-> $fell(sclk) || since_fall <= 4'h6;
    endproperty
    a_dout_on_fall: assert property (p_dout_on_fall)
        else $error("read data changed away from a falling edge");

    property p_self_high;
        sclk_dev_oe && $past(sclk_dev_oe) && $rose(sclk_dev)
            |-> sclk_dev[*4] ##1 !sclk_dev;
    endproperty
    a_self_high: assert property (p_self_high)
        else $error("self clock high time wrong");

    property p_strobes_excl;
        read_frame_strobe_n || write_frame_strobe_n;
    endproperty
    a_strobes_excl: assert property (p_strobes_excl)
        else $error("both frame strobes low");

    property p_sel_setup;
        $fell(read_frame_strobe_n) || $fell(write_frame_strobe_n)
            |-> register_select == $past(register_select)
            && register_select == $past(register_select, 2);
    endproperty
    a_sel_setup: assert property (p_sel_setup)
        else $error("select not settled before strobe");

    property p_sel_hold;
        !read_frame_strobe_n && !$past(read_frame_strobe_n)
            |-> $stable(register_select);
    endproperty
    a_sel_hold: assert property (p_sel_hold)
        else $error("select changed during read frame");

    property p_ext_rate;
        !mode_self && sclk_host_oe && $changed(sclk_host)
            |=> $stable(sclk_host)[*2];
    endproperty
    a_ext_rate: assert property (p_ext_rate)
        else $error("host serial clock too fast");

    property p_din_hold;
        !mode_self && !write_frame_strobe_n && $rose(sclk)
            |-> $stable(din) ##1 $stable(din);
    endproperty
    a_din_hold: assert property (p_din_hold)
        else $error("write data moved around sample edge");
endmodule

// [dv/adc_serial_port_clocking_tb.sv]
`timescale 1ns/10ps
`define CHK(got, exp) \
    begin \
        n_checks++; \
        if ((got) !== (exp)) begin \
            err_count++; \
            $display("CHECK FAILED t=%0t got %0h exp %0h", $time, got, exp); \
        end \
    end

module adc_serial_port_clocking_tb;
    import adcsp_pkg::*;

    // ==========================================================
    // Signals
    logic              clk = 1'b0;
    logic              rst = 1'b1;
    logic              result_valid = 1'b0;
    logic              self_clock_mode = 1'b0;
    logic              start = 1'b0;
    logic              start_read = 1'b0;
    logic              start_select = 1'b0;
    logic              filter_sync_req = 1'b0;
    logic [WORD_W-1:0] ctrl_word = '0;
    logic [WORD_W-1:0] result_word = '0;
    logic [WORD_W-1:0] start_word = '0;
    logic [WORD_W-1:0] wr_word;
    logic [WORD_W-1:0] rd_word;
    logic              wr_to_data;
    logic              wr_valid;
    logic              filter_reset;
    logic              busy;
    logic              rd_valid;
    logic              result_ready;
    logic              sclk_q = 1'b1;
    logic              frame_q = 1'b0;
    logic              fr_q = 1'b0;
    logic              wr_sel = 1'b0;
    logic              frame;
    logic              drv;
    logic [WORD_W-1:0] wire_word = '0;
    logic [WORD_W-1:0] wr_last = '0;
    int                rises = 0;
    int                sync_len = 0;
    int                wr_seen = 0;
    int                rd_seen = 0;
    int                cyc = 0;
    int                err_count = 0;
    int                n_checks = 0;

    always #(CLK_NS / 2) clk = ~clk;

    adcsp_if bus ();

    adcsp_device i_adcsp_device (
        .clk          (clk),
        .rst          (rst),
        .bus          (bus),
        .ctrl_word    (ctrl_word),
        .result_word  (result_word),
        .result_valid (result_valid),
        .wr_word      (wr_word),
        .wr_to_data   (wr_to_data),
        .wr_valid     (wr_valid),
        .filter_reset (filter_reset)
    );

    adcsp_host i_adcsp_host (
        .clk             (clk),
        .rst             (rst),
        .bus             (bus),
        .self_clock_mode (self_clock_mode),
        .start           (start),
        .start_read      (start_read),
        .start_select    (start_select),
        .start_word      (start_word),
        .filter_sync_req (filter_sync_req),
        .busy            (busy),
        .rd_word         (rd_word),
        .rd_valid        (rd_valid),
        .result_ready    (result_ready)
    );

    adcsp_props i_adcsp_props (
        .clk                  (clk),
        .rst                  (rst),
        .mode_self            (bus.mode_self),
        .sclk_dev             (bus.sclk_dev),
        .sclk_dev_oe          (bus.sclk_dev_oe),
        .sclk_host            (bus.sclk_host),
        .sclk_host_oe         (bus.sclk_host_oe),
        .sclk                 (bus.sclk),
        .read_frame_strobe_n  (bus.read_frame_strobe_n),
        .write_frame_strobe_n (bus.write_frame_strobe_n),
        .register_select      (bus.register_select),
        .dout                 (bus.dout),
        .dout_oe              (bus.dout_oe),
        .din                  (bus.din)
    );

    // ==========================================================
    // Wire monitor: first word of each frame, sampled on driven rises
    assign frame = !(bus.read_frame_strobe_n && bus.write_frame_strobe_n);
    assign drv = bus.sclk_dev_oe || bus.sclk_host_oe;

    always @(posedge clk) begin
        sclk_q <= bus.sclk;
        frame_q <= frame;
        fr_q <= filter_reset;
        if (frame && !frame_q) begin
            rises <= 0;
        end else if (frame && drv && bus.sclk && !sclk_q
                     && rises < WORD_W) begin
            rises <= rises + 1;
            wire_word <= {wire_word[WORD_W-2:0],
                          bus.read_frame_strobe_n ? bus.din : bus.dout_line};
        end
        if (wr_valid) begin
            wr_last <= wr_word;
            wr_sel <= wr_to_data;
            wr_seen <= wr_seen + 1;
        end
        if (rd_valid) begin
            rd_seen <= rd_seen + 1;
        end
        if (filter_reset) begin
            sync_len <= fr_q ? sync_len + 1 : 1;
        end
    end

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_count++;
            tally_and_finish();
        end
    end

    // ==========================================================
    // Tasks
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic run_case(input logic self_m, input logic rd,
                            input logic sel, input logic [WORD_W-1:0] w);
        int wr0;
        int rd0;
        int n;
        wr0 = wr_seen;
        rd0 = rd_seen;
        n = 0;
        if (rd && !sel) begin
            ctrl_word = w;
        end
        if (rd && sel) begin
            result_word = w;
            result_valid = 1'b1;
            @(posedge clk);
            #1 result_valid = 1'b0;
            while (result_ready !== 1'b1 && n < 20) begin
                @(posedge clk);
                #1 n++;
            end
            `CHK(bus.result_ready_n, 1'b0)
        end
        self_clock_mode = self_m;
        start_read = rd;
        start_select = sel;
        start_word = w;
        start = 1'b1;
        @(posedge clk);
        #1 start = 1'b0;
        n = 0;
        while (busy !== 1'b0 && n < 2000) begin
            @(posedge clk);
            #1 n++;
        end
        `CHK(busy, 1'b0)
        `CHK(bus.sclk, 1'b1)
        `CHK(wire_word, w)
        if (rd) begin
            `CHK(rd_word, w)
            `CHK(rd_seen, rd0 + 1)
            if (sel) begin
                `CHK(result_ready, 1'b0)
            end
        end else begin
            `CHK(wr_last, w)
            `CHK(wr_sel, sel)
            `CHK(wr_seen, wr0 + 1)
        end
    endtask

    task automatic filter_check();
        int n;
        n = 0;
        filter_sync_req = 1'b1;
        @(posedge clk);
        #1 filter_sync_req = 1'b0;
        while (!(fr_q === 1'b1 && filter_reset === 1'b0) && n < 200) begin
            @(posedge clk);
            #1 n++;
        end
        `CHK(sync_len, SYNC_MIN_CYC)
        `CHK(bus.filter_sync_n, 1'b1)
    endtask

    // ==========================================================
    // Sequence: every mode, direction and target, back to back
    initial begin
        repeat (16) @(posedge clk);
        #1 rst = 1'b0;
        @(posedge clk);
        #1;
        for (int i = 0; i < 8; i++) begin
            run_case(i[2], i[1], i[0],
                     WORD_W'(24'h81A5C3 ^ (24'h13579B * i)));
        end
        filter_check();
        tally_and_finish();
    end
endmodule
